// ===== hw/mpt_top.sv
// Behaviour
// RULE1: seven match registers feed up to six single or three double-edge outputs
// RULE2: cycle match register equal to counter resets counter, fixing shared period
// RULE3: single-edge output falls at the count of its own match register
// RULE4: single-edge outputs rise at cycle start unless held constantly low
// RULE5: double-edge output rises on one match, falls on next; either order
// RULE6: each extra output uses one or two more matches, same cycle
// RULE7: written match values wait for release, then apply at cycle start
// RULE8: per match: continue, stop or reset counter, optionally raising interrupt
// RULE9: counter advances on pclk or on edges of a selected capture input
// RULE10: 32-bit counter behind a 32-bit programmable prescaler
// RULE11: period and pulse width are any number of counts
// RULE12: with pulse mode off, block is a plain timer, outputs stay low
// RULE13: cycle match reset returns counter to zero on next prescaled count
`include "mpt_defs.svh"

module mpt_top import mpt_pkg::*; #(
   parameter int CW = `MPT_CW,
   parameter int NM = `MPT_NM
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`MPT_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [`MPT_NCAP-1:0] cap_in,
   output logic [NM-1:1] pwm_out,
   output logic irq
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic hit_off(input logic [`MPT_AW-1:0] a, input logic [`MPT_AW-1:0] off);
      hit_off = (a == off);
   endfunction

   // match slot index, or NM when the address is not a match register
   function automatic int match_idx(input logic [`MPT_AW-1:0] a);
      int k;
      k = NM;
      for (int i = 0; i < NM; i++) begin
         if (a == `MPT_OFF_MATCH0 + `MPT_AW'(4 * i)) begin
            k = i;
         end
      end
      match_idx = k;
   endfunction

   // ****************************************
   // state
   // ****************************************
   mpt_ctrl_t ctrl, next_ctrl;
   mpt_mode_t mode, next_mode;
   logic [CW-1:0] tc, next_tc;
   logic [CW-1:0] pr, next_pr;
   logic [CW-1:0] pc, next_pc;
   mpt_mact_t mact [NM];
   mpt_mact_t next_mact [NM];
   logic [CW-1:0] shadow [NM];
   logic [CW-1:0] next_shadow [NM];
   logic [CW-1:0] active [NM];
   logic [CW-1:0] next_active [NM];
   logic [NM-1:1] dbl, next_dbl;
   logic [NM-1:1] oen, next_oen;
   logic [NM-1:0] release_q, next_release;
   logic [NM-1:0] stat, next_stat;
   logic [NM-1:0] mask, next_mask;
   logic cap_q, next_cap_q;
   logic [NM-1:1] next_pwm;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_irq;

   // ****************************************
   // combinational next state
   // ****************************************
   logic acc;
   logic wr;
   logic cap_now;
   logic cnt_evt;
   logic run;
   logic tick;
   logic [NM-1:0] hit;
   logic reset_hit;
   logic stop_hit;
   logic cyc;
   logic setv;
   int mi;

   always_comb begin
      next_ctrl = ctrl;
      next_mode = mode;
      next_pr = pr;
      next_dbl = dbl;
      next_oen = oen;
      next_release = release_q;
      next_mask = mask;
      for (int i = 0; i < NM; i++) begin
         next_mact[i] = mact[i];
         next_shadow[i] = shadow[i];
      end

      // write takes effect only on the completing access edge
      acc = psel & penable & pready;
      wr = acc & pwrite;
      mi = match_idx(paddr);

      // ---- counting source
      cap_now = cap_in[mode.cap_sel];
      next_cap_q = cap_now;
      unique case (mode.cmode)
         MPT_TIMER: cnt_evt = 1'b1; // RULE9
         MPT_RISE: cnt_evt = cap_now & ~cap_q; // RULE9
         MPT_FALL: cnt_evt = ~cap_now & cap_q; // RULE9
         MPT_BOTH: cnt_evt = cap_now ^ cap_q; // RULE9
      endcase
      run = ctrl.cnt_en & ~ctrl.cnt_rst;
      tick = run & cnt_evt & (pc == pr); // RULE10

      // ---- matches against the applied copies
      for (int i = 0; i < NM; i++) begin
         hit[i] = tick & (tc == active[i]); // RULE1 RULE11
      end
      reset_hit = 1'b0;
      stop_hit = 1'b0;
      for (int i = 0; i < NM; i++) begin
         reset_hit = reset_hit | (hit[i] & mact[i].rst); // RULE8
         stop_hit = stop_hit | (hit[i] & mact[i].stop); // RULE8
      end
      cyc = hit[0] & mact[0].rst; // RULE2

      // ---- prescaler and counter
      if (ctrl.cnt_rst) begin
         next_pc = '0;
      end else if (run & cnt_evt) begin
         next_pc = (pc == pr) ? '0 : pc + CW'(1); // RULE10
      end else begin
         next_pc = pc;
      end
      if (ctrl.cnt_rst) begin
         next_tc = '0;
      end else if (tick) begin
         // zero lands on the count after the match: period is match+1
         next_tc = reset_hit ? '0 : tc + CW'(1); // RULE2 RULE13
      end else begin
         next_tc = tc;
      end

      // ---- release of new match values
      for (int i = 0; i < NM; i++) begin
         if (!ctrl.pwm_en) begin
            next_active[i] = shadow[i]; // RULE12
         end else if (release_q[i] & cyc) begin
            next_active[i] = shadow[i]; // RULE7
         end else begin
            next_active[i] = active[i];
         end
      end
      if (ctrl.pwm_en & cyc) begin
         next_release = '0; // RULE7
      end

      // ---- pulse outputs; clear beats set so equal matches give constant low
      for (int n = 1; n < NM; n++) begin
         setv = dbl[n] ? hit[n-1] : hit[0]; // RULE3 RULE4 RULE5 RULE6
         if (!ctrl.pwm_en || !oen[n]) begin
            next_pwm[n] = 1'b0; // RULE12
         end else if (hit[n]) begin
            next_pwm[n] = 1'b0; // RULE3 RULE5
         end else if (setv) begin
            next_pwm[n] = 1'b1; // RULE4 RULE5
         end else begin
            next_pwm[n] = pwm_out[n];
         end
      end

      // ---- register writes
      if (wr) begin
         if (hit_off(paddr, `MPT_OFF_CTRL)) begin
            next_ctrl = mpt_ctrl_t'(pwdata[2:0]);
         end
         if (hit_off(paddr, `MPT_OFF_PRESCALE)) begin
            next_pr = pwdata[CW-1:0];
         end
         if (hit_off(paddr, `MPT_OFF_MODE)) begin
            next_mode = mpt_mode_t'(pwdata[3:0]);
         end
         if (hit_off(paddr, `MPT_OFF_MACT)) begin
            for (int i = 0; i < NM; i++) begin
               next_mact[i] = mpt_mact_t'(pwdata[i*`MPT_MACT_W +: `MPT_MACT_W]);
            end
         end
         if (hit_off(paddr, `MPT_OFF_OUTSEL)) begin
            next_dbl = pwdata[`MPT_OUTSEL_DBL_LSB +: NM-1];
            next_oen = pwdata[`MPT_OUTSEL_OEN_LSB +: NM-1];
         end
         if (hit_off(paddr, `MPT_OFF_RELEASE)) begin
            // software release wins over the cycle-start clear
            next_release = next_release | pwdata[NM-1:0]; // RULE7
         end
         if (hit_off(paddr, `MPT_OFF_MASK)) begin
            next_mask = pwdata[NM-1:0];
         end
         if (mi < NM) begin
            next_shadow[mi] = pwdata[CW-1:0]; // RULE7
         end
      end

      // ---- stop on match clears the enable after any write
      if (stop_hit) begin
         next_ctrl.cnt_en = 1'b0; // RULE8
      end

      // ---- sticky events, set wins over write-one-to-clear
      next_stat = stat;
      if (wr && hit_off(paddr, `MPT_OFF_STATUS)) begin
         next_stat = stat & ~pwdata[NM-1:0];
      end
      for (int i = 0; i < NM; i++) begin
         if (hit[i] & mact[i].irq) begin
            next_stat[i] = 1'b1; // RULE8
         end
      end
      next_irq = |(next_stat & next_mask);

      // ---- apb answer: one wait state, data and error from flops
      next_pready = psel & penable & ~pready;
      next_prdata = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (psel & penable & ~pready) begin
         if (hit_off(paddr, `MPT_OFF_CTRL)) begin
            next_prdata[2:0] = ctrl;
         end else if (hit_off(paddr, `MPT_OFF_COUNT)) begin
            next_prdata[CW-1:0] = tc;
         end else if (hit_off(paddr, `MPT_OFF_PRESCALE)) begin
            next_prdata[CW-1:0] = pr;
         end else if (hit_off(paddr, `MPT_OFF_PRECOUNT)) begin
            next_prdata[CW-1:0] = pc;
         end else if (hit_off(paddr, `MPT_OFF_MODE)) begin
            next_prdata[3:0] = mode;
         end else if (hit_off(paddr, `MPT_OFF_MACT)) begin
            for (int i = 0; i < NM; i++) begin
               next_prdata[i*`MPT_MACT_W +: `MPT_MACT_W] = mact[i];
            end
         end else if (hit_off(paddr, `MPT_OFF_OUTSEL)) begin
            next_prdata[`MPT_OUTSEL_DBL_LSB +: NM-1] = dbl;
            next_prdata[`MPT_OUTSEL_OEN_LSB +: NM-1] = oen;
         end else if (hit_off(paddr, `MPT_OFF_RELEASE)) begin
            next_prdata[NM-1:0] = release_q;
         end else if (hit_off(paddr, `MPT_OFF_STATUS)) begin
            next_prdata[NM-1:0] = stat;
         end else if (hit_off(paddr, `MPT_OFF_MASK)) begin
            next_prdata[NM-1:0] = mask;
         end else if (mi < NM) begin
            // reads show the pending value, not the applied one
            next_prdata[CW-1:0] = shadow[mi];
         end else begin
            next_pslverr = 1'b1;
         end
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= mpt_ctrl_t'(`MPT_RST_CTRL);
         mode <= mpt_mode_t'(`MPT_RST_MODE);
         tc <= '0;
         pr <= '0;
         pc <= '0;
         for (int i = 0; i < NM; i++) begin
            mact[i] <= '0;
            shadow[i] <= '0;
            active[i] <= '0;
         end
         dbl <= '0;
         oen <= '0;
         release_q <= '0;
         stat <= '0;
         mask <= '0;
         cap_q <= 1'b0;
         pwm_out <= '0;
         prdata <= `MPT_RST_WORD;
         pready <= 1'b0;
         pslverr <= 1'b0;
         irq <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         mode <= next_mode;
         tc <= next_tc;
         pr <= next_pr;
         pc <= next_pc;
         for (int i = 0; i < NM; i++) begin
            mact[i] <= next_mact[i];
            shadow[i] <= next_shadow[i];
            active[i] <= next_active[i];
         end
         dbl <= next_dbl;
         oen <= next_oen;
         release_q <= next_release;
         stat <= next_stat;
         mask <= next_mask;
         cap_q <= next_cap_q;
         pwm_out <= next_pwm;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         irq <= next_irq;
      end
   end

endmodule

// ===== hw/mpt_defs.svh
`ifndef MPT_DEFS_SVH
`define MPT_DEFS_SVH

// ****************************************
// sizes
// ****************************************
`define MPT_NM 7
`define MPT_CW 32
`define MPT_NCAP 4
`define MPT_AW 8

// ****************************************
// register byte offsets
// ****************************************
`define MPT_OFF_CTRL 8'h00
`define MPT_OFF_COUNT 8'h04
`define MPT_OFF_PRESCALE 8'h08
`define MPT_OFF_PRECOUNT 8'h0C
`define MPT_OFF_MODE 8'h10
`define MPT_OFF_MACT 8'h14
`define MPT_OFF_OUTSEL 8'h18
`define MPT_OFF_RELEASE 8'h1C
`define MPT_OFF_STATUS 8'h20
`define MPT_OFF_MASK 8'h24
`define MPT_OFF_MATCH0 8'h40

// ****************************************
// field positions
// ****************************************
`define MPT_MACT_W 3
`define MPT_OUTSEL_DBL_LSB 1
`define MPT_OUTSEL_OEN_LSB 9

// ****************************************
// reset values
// ****************************************
`define MPT_RST_CTRL 3'h0
`define MPT_RST_MODE 4'h0
`define MPT_RST_WORD 32'h0000_0000
`define MPT_RST_MACT 21'h00_0000
`define MPT_RST_NM 7'h00
`define MPT_RST_OUT 6'h00

`endif

// ===== hw/mpt_pkg.sv
`include "mpt_defs.svh"

package mpt_pkg;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      MPT_TIMER = 2'h0,
      MPT_RISE = 2'h1,
      MPT_FALL = 2'h2,
      MPT_BOTH = 2'h3
   } mpt_cmode_t;

   typedef struct packed {
      logic pwm_en;
      logic cnt_rst;
      logic cnt_en;
   } mpt_ctrl_t;

   typedef struct packed {
      logic [1:0] cap_sel;
      mpt_cmode_t cmode;
   } mpt_mode_t;

   typedef struct packed {
      logic stop;
      logic rst;
      logic irq;
   } mpt_mact_t;
endpackage

// ===== verif/mpt_load.sv
// ***
// load model: integrates on-time per output
// ***
module mpt_load (
   input wire logic pclk,
   input wire logic clr,
   input wire logic [6:1] pwm_out,
   output logic [7:0] hi_cnt [1:6]
);
   timeunit 1ns;
   timeprecision 1ns;
   // a drive stage only sees the average, so phase never matters here
   always_ff @(posedge pclk) begin
      for (int n = 1; n <= 6; n++) begin
         hi_cnt[n] <= clr ? 8'h00 : hi_cnt[n] + {7'h00, pwm_out[n]};
      end
   end
endmodule

// ===== verif/mpt_top_chk.sv
`include "mpt_defs.svh"

module mpt_top_chk import mpt_pkg::*; #(
   parameter int NM = `MPT_NM
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`MPT_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [`MPT_NCAP-1:0] cap_in,
   input wire logic [NM-1:1] pwm_out,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ***
   // sequences
   // ***
   sequence first_access;
      psel && $rose(penable);
   endsequence
   sequence ctrl_off_wr;
      pready && pwrite && paddr == `MPT_OFF_CTRL && !pwdata[2];
   endsequence
   sequence mask_off_wr;
      pready && pwrite && paddr == `MPT_OFF_MASK && pwdata[6:0] == 7'h00;
   endsequence
   // ***
   // assertions
   // ***
   ready_timing_a:
      assert property (first_access |=> pready) else $error("late ready");
   ready_pulse_a:
      assert property (pready |=> !pready) else $error("ready too long");
   ready_in_access_a:
      assert property (pready |-> psel && penable) else $error("stray ready");
   rdata_idle_a:
      assert property (!pready |-> prdata == 32'h0) else $error("rdata not idle");
   err_unmapped_a:
      assert property (pready && paddr == 8'h28 |-> pslverr) else $error("no error");
   err_mapped_a:
      assert property (pready && paddr <= `MPT_OFF_MASK |-> !pslverr) else $error("false error");
   out_reset_a:
      assert property ($rose(presetn) |-> pwm_out == '0 && !irq) else $error("outputs after reset");
   pwm_off_a:
      assert property (ctrl_off_wr |-> ##2 pwm_out == '0) else $error("output in timer mode");
   irq_masked_a:
      assert property (mask_off_wr |=> ##1 !irq) else $error("irq while masked");
endmodule

bind mpt_top mpt_top_chk #(.NM(NM)) mpt_top_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq));

// ===== verif/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, clr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] cap_in;
   logic [6:1] pwm_out;
   logic [7:0] hi_cnt [1:6];
   int err_count, num_checks, cyc;
   int m [7] = '{9, 2, 7, 1, 0, 5, 9};
   mpt_top mpt_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq));
   mpt_load mpt_load_i (.pclk(pclk), .clr(clr), .pwm_out(pwm_out), .hi_cnt(hi_cnt));
   // ***
   // tasks
   // ***
   task give_verdict;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, g, e);
      end
   endtask
   // no fixed latency assumed; the timeout ends a hang
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   task measure;
      repeat (20) @(posedge pclk);
      clr <= 1'b1;
      @(posedge pclk);
      clr <= 1'b0;
      // one extra edge: counts are read settled, before this edge's update
      repeat (101) @(posedge pclk);
   endtask
   task pulses(input int n);
      for (int k = 0; k < n; k++) begin
         cap_in[2] <= 1'b1;
         repeat (2) @(posedge pclk);
         cap_in[2] <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask
   // ***
   // clock, timeout, sequence
   // ***
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         give_verdict;
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      cap_in = 4'h0;
      clr = 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(8'h00, 32'h0);
      rdc(8'h28, 32'h0);
      chk(32'(er), 32'h1);
      for (int i = 0; i < 7; i++) wr(8'h40 + 8'(4 * i), 32'(m[i]));
      rdc(8'h44, 32'h2);
      wr(8'h14, 32'h3);
      wr(8'h18, 32'h5E0C);
      wr(8'h24, 32'h1);
      wr(8'h00, 32'h5);
      measure;
      chk(32'(hi_cnt[1]), 32'((m[1] + 1) * 10));
      chk(32'(hi_cnt[2]), 32'((m[2] - m[1]) * 10));
      chk(32'(hi_cnt[3]), 32'(((m[3] - m[2] + 10) % 10) * 10));
      chk(32'(hi_cnt[4]), 32'((m[4] + 1) * 10));
      chk(32'(hi_cnt[5]), 32'h0);
      chk(32'(hi_cnt[6]), 32'h0);
      chk(32'(irq), 32'h1);
      wr(8'h44, 32'h5);
      measure;
      chk(32'(hi_cnt[1]), 32'h1E);
      wr(8'h1C, 32'h2);
      measure;
      chk(32'(hi_cnt[1]), 32'h3C);
      chk(32'(hi_cnt[2]), 32'h14);
      wr(8'h24, 32'h0);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h20, 32'h7F);
      rdc(8'h20, 32'h0);
      wr(8'h24, 32'h1);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
      wr(8'h00, 32'h2);
      wr(8'h10, 32'h9);
      wr(8'h00, 32'h1);
      pulses(5);
      rdc(8'h04, 32'h5);
      wr(8'h04, 32'h77);
      rdc(8'h04, 32'h5);
      chk(32'(pwm_out), 32'h0);
      wr(8'h10, 32'hA);
      pulses(3);
      rdc(8'h04, 32'h8);
      wr(8'h10, 32'hB);
      pulses(2);
      rdc(8'h04, 32'h2);
      chk(32'(irq), 32'h1);
      wr(8'h00, 32'h2);
      wr(8'h10, 32'h0);
      wr(8'h14, 32'hA00);
      wr(8'h20, 32'h7F);
      wr(8'h00, 32'h1);
      repeat (8) @(posedge pclk);
      rdc(8'h00, 32'h0);
      rdc(8'h20, 32'h8);
      wr(8'h24, 32'h8);
      chk(32'(irq), 32'h1);
      wr(8'h08, 32'hFFFF_FFFF);
      rdc(8'h08, 32'hFFFF_FFFF);
      give_verdict;
   end
endmodule
